// *** core/bcg_regs.sv ***
// Bridge control and status word with GPIO port and interrupt
// Functional notes
// - In forward mode with forwarding enabled, a conventional error assertion becomes a fatal error message; the bit is read-only in reverse mode.
// - The secondary-reset bit holds the secondary bus reset in forward mode or a link hot reset in reverse mode while it is one.
// - VGA field 00 forwards no VGA traffic in either direction.
// - VGA field 01 forwards VGA traffic from primary to secondary only, untranslated.
// - VGA field 10 forwards VGA traffic from secondary to primary only, untranslated.
// - VGA IO decode uses ten address bits, or sixteen when the wide-decode bit is one.
// - With master-abort mode zero, aborted reads return all ones and aborted writes are dropped.
// - With master-abort mode one, a master abort gives target abort where allowed, else the system error pin if reporting is on.
// - The primary discard timer runs 2^15 or 2^10 clocks by its bit, which is read-only and ignored in forward mode.
// - The secondary discard timer runs 2^15 or 2^10 clocks by its bit, which is read-only and ignored in reverse mode.
// - A discard timer expiry with a dropped delayed completion sets the timeout flag, cleared by writing one.
// - With the expiry error enable set, an expiry gives a non-fatal message forward or the error pin reverse, but not in PCI-X mode.
// - Four GPIO pins with set and clear nibbles for value and enable, pin levels readable, all reset to zero.
`timescale 1ns/1ns
`default_nettype none
`include "bcg_defines.svh"
module bcg_regs (
	// Clock and reset
	input  wire logic                  CLK_I,
	input  wire logic                  RSTN_I,
	// Register port
	input  wire logic [`BCG_AW-1:0]    ADDR_I,
	input  wire logic [31:0]           WDATA_I,
	input  wire logic                  WE_I,
	input  wire logic                  RE_I,
	output logic [31:0]                RDATA_O,
	// Bridge mode
	input  wire logic                  REVERSE_I,
	input  wire logic                  PCIX_MODE_I,
	// Error forwarding and reset
	input  wire logic                  SERR_IN_N_I,
	output logic                       ERR_FATAL_O,
	output logic                       ERR_NONFATAL_O,
	output logic                       SERR_OUT_N_O,
	output logic                       SEC_RESET_N_O,
	output logic                       HOT_RESET_O,
	// VGA decode
	input  wire logic                  VGA_VLD_I,
	input  wire logic                  VGA_IO_I,
	input  wire logic                  VGA_PRI_I,
	input  wire logic [31:0]           VGA_ADDR_I,
	output logic                       VGA_CLAIM_O,
	// Master abort handling
	input  wire logic                  MA_I,
	input  wire logic                  MA_RD_I,
	input  wire logic                  TABORT_OK_I,
	input  wire logic                  SERR_EN_I,
	output logic                       MA_ONES_O,
	output logic [31:0]                MA_RDATA_O,
	output logic                       MA_DROP_O,
	output logic                       MA_TABORT_O,
	// Discard timers
	input  wire logic                  DISCARD_EXP_I,
	output logic [15:0]                PRI_DT_LEN_O,
	output logic [15:0]                SEC_DT_LEN_O,
	// GPIO pins
	input  wire logic [3:0]            GPIO_I,
	output logic [3:0]                 GPIO_O,
	output logic [3:0]                 GPIO_OE_O,
	// Interrupt
	output logic                       IRQ_O
);
	logic        fwd;
	logic        wr_ctl;
	logic        serr_fall;
	logic        ev_fatal;
	logic        ev_nf;
	logic        ev_serr;
	logic [3:0]  gin_ff;
	logic [3:0]  nxt_gin;
	logic [11:0] ctl_ff;
	logic [11:0] nxt_ctl;
	logic        serr_d_ff;
	logic        fatal_ff;
	logic        nf_ff;
	logic        serr_ff;
	logic        ones_ff;
	logic        drop_ff;
	logic        tab_ff;
	logic        nxt_serr_d;
	logic        nxt_fatal;
	logic        nxt_nf;
	logic        nxt_serr;
	logic        nxt_ones;
	logic        nxt_drop;
	logic        nxt_tab;
	logic [2:0]  ist_ff;
	logic [2:0]  imk_ff;
	logic [2:0]  nxt_ist;
	logic [2:0]  nxt_imk;
	logic [31:0] rd_ff;
	logic [31:0] nxt_rd;
	logic [31:0] ctl_word;

	assign fwd = !REVERSE_I;
	assign wr_ctl = WE_I && ADDR_I == `BCG_OFS_CTL;

	// Control bits, mode-locked bits refuse writes
	always_comb
	begin
		nxt_ctl = ctl_ff;
		if (wr_ctl)
		begin
			if (fwd)
				nxt_ctl[`BCG_B_SFE] = WDATA_I[`BCG_B_SFE];
			nxt_ctl[`BCG_B_SRST] = WDATA_I[`BCG_B_SRST];
			nxt_ctl[`BCG_B_VGA+:2] = WDATA_I[`BCG_B_VGA+:2];
			nxt_ctl[`BCG_B_V16] = WDATA_I[`BCG_B_V16];
			nxt_ctl[`BCG_B_MAM] = WDATA_I[`BCG_B_MAM];
			if (!fwd)
				nxt_ctl[`BCG_B_PDT] = WDATA_I[`BCG_B_PDT];
			if (fwd)
				nxt_ctl[`BCG_B_SDT] = WDATA_I[`BCG_B_SDT];
			nxt_ctl[`BCG_B_DTSE] = WDATA_I[`BCG_B_DTSE];
			if (WDATA_I[`BCG_B_MTS])
				nxt_ctl[`BCG_B_MTS] = 1'b0;
		end
		if (DISCARD_EXP_I)
			nxt_ctl[`BCG_B_MTS] = 1'b1;
		nxt_ctl[1:0] = 2'h0;
	end

	// Control register
	always_ff @(posedge CLK_I)
	begin
		if (!RSTN_I)
			ctl_ff <= `BCG_CTL_RST;
		else
			ctl_ff <= nxt_ctl;
	end

	// Reset drive and timer lengths from the control bits
	assign SEC_RESET_N_O = !(fwd && ctl_ff[`BCG_B_SRST]);
	assign HOT_RESET_O = !fwd && ctl_ff[`BCG_B_SRST];
	assign PRI_DT_LEN_O = (!fwd && ctl_ff[`BCG_B_PDT]) ? `BCG_DT_SHORT : `BCG_DT_LONG;
	assign SEC_DT_LEN_O = (fwd && ctl_ff[`BCG_B_SDT]) ? `BCG_DT_SHORT : `BCG_DT_LONG;

	// Error events
	assign serr_fall = serr_d_ff && !SERR_IN_N_I;
	assign ev_fatal = fwd && ctl_ff[`BCG_B_SFE] && serr_fall;
	assign ev_nf = fwd && ctl_ff[`BCG_B_DTSE] && !PCIX_MODE_I && DISCARD_EXP_I;
	assign ev_serr = (!fwd && ctl_ff[`BCG_B_DTSE] && !PCIX_MODE_I && DISCARD_EXP_I) ||
		(MA_I && ctl_ff[`BCG_B_MAM] && !TABORT_OK_I && SERR_EN_I);

	// Event pulses and master abort answers
	always_comb
	begin
		nxt_serr_d = SERR_IN_N_I;
		nxt_fatal = ev_fatal;
		nxt_nf = ev_nf;
		nxt_serr = ev_serr;
		nxt_ones = MA_I && MA_RD_I && !ctl_ff[`BCG_B_MAM];
		nxt_drop = MA_I && !MA_RD_I && !ctl_ff[`BCG_B_MAM];
		nxt_tab = MA_I && ctl_ff[`BCG_B_MAM] && TABORT_OK_I;
	end

	// Event registers
	always_ff @(posedge CLK_I)
	begin
		if (!RSTN_I)
		begin
			serr_d_ff <= 1'b1;
			fatal_ff <= 1'b0;
			nf_ff <= 1'b0;
			serr_ff <= 1'b0;
			ones_ff <= 1'b0;
			drop_ff <= 1'b0;
			tab_ff <= 1'b0;
		end
		else
		begin
			serr_d_ff <= nxt_serr_d;
			fatal_ff <= nxt_fatal;
			nf_ff <= nxt_nf;
			serr_ff <= nxt_serr;
			ones_ff <= nxt_ones;
			drop_ff <= nxt_drop;
			tab_ff <= nxt_tab;
		end
	end

	assign ERR_FATAL_O = fatal_ff;
	assign ERR_NONFATAL_O = nf_ff;
	assign SERR_OUT_N_O = !serr_ff;
	assign MA_ONES_O = ones_ff;
	assign MA_RDATA_O = ones_ff ? `BCG_MA_DATA : 32'h0;
	assign MA_DROP_O = drop_ff;
	assign MA_TABORT_O = tab_ff;

	// Sticky interrupt flags, set beats write-one clear
	always_comb
	begin
		nxt_imk = imk_ff;
		nxt_ist = ist_ff;
		if (WE_I && ADDR_I == `BCG_OFS_IMK)
			nxt_imk = WDATA_I[2:0];
		if (WE_I && ADDR_I == `BCG_OFS_IST)
			nxt_ist = ist_ff & ~WDATA_I[2:0];
		nxt_ist = nxt_ist | {MA_I, ev_fatal | ev_nf | ev_serr, DISCARD_EXP_I};
		nxt_gin = GPIO_I;
	end

	// Interrupt and pin sample registers
	always_ff @(posedge CLK_I)
	begin
		if (!RSTN_I)
		begin
			ist_ff <= `BCG_INT_RST;
			imk_ff <= `BCG_INT_RST;
			gin_ff <= `BCG_NIB_RST;
		end
		else
		begin
			ist_ff <= nxt_ist;
			imk_ff <= nxt_imk;
			gin_ff <= nxt_gin;
		end
	end

	assign IRQ_O = |(ist_ff & imk_ff);

	// Read word of the shared offset
	assign ctl_word = {gin_ff, GPIO_OE_O, GPIO_OE_O, GPIO_O, GPIO_O, ctl_ff};

	// Read data, valid only in the cycle after the strobe
	always_comb
	begin
		nxt_rd = 32'h0;
		if (RE_I)
		begin
			unique case (ADDR_I)
				`BCG_OFS_CTL: nxt_rd = ctl_word;
				`BCG_OFS_IST: nxt_rd = {29'h0, ist_ff};
				`BCG_OFS_IMK: nxt_rd = {29'h0, imk_ff};
				default: nxt_rd = 32'h0;
			endcase
		end
	end

	// Read register
	always_ff @(posedge CLK_I)
	begin
		if (!RSTN_I)
			rd_ff <= 32'h0;
		else
			rd_ff <= nxt_rd;
	end

	assign RDATA_O = rd_ff;

	// GPIO value and enable
	bcg_gpio u_gpio (
		.clk_i     (CLK_I),
		.rstn_i    (RSTN_I),
		.wr_i      (wr_ctl),
		.out_set_i (WDATA_I[`BCG_B_GOS+:4]),
		.out_clr_i (WDATA_I[`BCG_B_GOC+:4]),
		.oe_set_i  (WDATA_I[`BCG_B_GES+:4]),
		.oe_clr_i  (WDATA_I[`BCG_B_GEC+:4]),
		.out_o     (GPIO_O),
		.oe_o      (GPIO_OE_O)
	);

	// VGA window decode
	bcg_vga u_vga (
		.clk_i   (CLK_I),
		.rstn_i  (RSTN_I),
		.mode_i  (bcg_pkg::bcg_vga_type'(ctl_ff[`BCG_B_VGA+:2])),
		.dec16_i (ctl_ff[`BCG_B_V16]),
		.vld_i   (VGA_VLD_I),
		.io_i    (VGA_IO_I),
		.pri_i   (VGA_PRI_I),
		.addr_i  (VGA_ADDR_I),
		.claim_o (VGA_CLAIM_O)
	);

	property p_fatal;
		@(posedge CLK_I) disable iff (!RSTN_I)
		(fwd && ctl_ff[`BCG_B_SFE] && serr_d_ff && !SERR_IN_N_I) |=> ERR_FATAL_O ##1 !ERR_FATAL_O;
	endproperty
	a_fatal: assert property (p_fatal) else $error("fatal message missing");

	property p_sfe_ro;
		@(posedge CLK_I) disable iff (!RSTN_I)
		(REVERSE_I && wr_ctl) |=> $stable(ctl_ff[`BCG_B_SFE]);
	endproperty
	a_sfe_ro: assert property (p_sfe_ro) else $error("forward enable written in reverse");

	property p_srst;
		@(posedge CLK_I) disable iff (!RSTN_I)
		ctl_ff[`BCG_B_SRST] |-> (REVERSE_I ? (HOT_RESET_O && SEC_RESET_N_O) : !SEC_RESET_N_O);
	endproperty
	a_srst: assert property (p_srst) else $error("secondary reset not held");

	property p_ma_hide;
		@(posedge CLK_I) disable iff (!RSTN_I)
		(MA_I && !ctl_ff[`BCG_B_MAM]) |=> (MA_ONES_O ^ MA_DROP_O) && !MA_TABORT_O && SERR_OUT_N_O;
	endproperty
	a_ma_hide: assert property (p_ma_hide) else $error("master abort not hidden");

	property p_ma_rep;
		@(posedge CLK_I) disable iff (!RSTN_I)
		(MA_I && ctl_ff[`BCG_B_MAM] && !TABORT_OK_I && SERR_EN_I) |=> !SERR_OUT_N_O;
	endproperty
	a_ma_rep: assert property (p_ma_rep) else $error("master abort not reported");

	property p_pdt;
		@(posedge CLK_I) disable iff (!RSTN_I)
		fwd |-> PRI_DT_LEN_O == 16'h8000;
	endproperty
	a_pdt: assert property (p_pdt) else $error("primary timer select active in forward");

	property p_sdt;
		@(posedge CLK_I) disable iff (!RSTN_I)
		(fwd && ctl_ff[`BCG_B_SDT]) |-> SEC_DT_LEN_O == 16'h0400;
	endproperty
	a_sdt: assert property (p_sdt) else $error("secondary short timer wrong");

	property p_mts;
		@(posedge CLK_I) disable iff (!RSTN_I)
		DISCARD_EXP_I |=> ctl_ff[`BCG_B_MTS] && ist_ff[0];
	endproperty
	a_mts: assert property (p_mts) else $error("timeout flag lost");

	property p_nf;
		@(posedge CLK_I) disable iff (!RSTN_I)
		(DISCARD_EXP_I && PCIX_MODE_I) |=> !ERR_NONFATAL_O;
	endproperty
	a_nf: assert property (p_nf) else $error("expiry message in PCI-X mode");

	c_fatal: cover property (@(posedge CLK_I) ERR_FATAL_O);
	c_hot: cover property (@(posedge CLK_I) HOT_RESET_O);
	c_irq: cover property (@(posedge CLK_I) IRQ_O ##1 !IRQ_O);
endmodule
`default_nettype wire

// *** core/bcg_defines.svh ***
// Offsets, field positions, reset values and timer counts of the bridge control block
`ifndef BCG_DEFINES_SVH
`define BCG_DEFINES_SVH
`define BCG_AW 9
`define BCG_OFS_CTL 9'h078
`define BCG_OFS_IST 9'h100
`define BCG_OFS_IMK 9'h104
`define BCG_B_SFE 2
`define BCG_B_SRST 3
`define BCG_B_VGA 4
`define BCG_B_V16 6
`define BCG_B_MAM 7
`define BCG_B_PDT 8
`define BCG_B_SDT 9
`define BCG_B_MTS 10
`define BCG_B_DTSE 11
`define BCG_B_GOC 12
`define BCG_B_GOS 16
`define BCG_B_GEC 20
`define BCG_B_GES 24
`define BCG_B_GIN 28
`define BCG_CTL_RST 12'h000
`define BCG_NIB_RST 4'h0
`define BCG_INT_RST 3'h0
`define BCG_DT_LONG_LOG 15
`define BCG_DT_SHORT_LOG 10
`define BCG_DT_LONG 16'(32'h1 << `BCG_DT_LONG_LOG)
`define BCG_DT_SHORT 16'(32'h1 << `BCG_DT_SHORT_LOG)
`define BCG_MA_DATA 32'hffffffff
`endif

// *** core/bcg_pkg.sv ***
// Types shared by the bridge control block
package bcg_pkg;
	typedef enum logic [1:0] {
		BCG_VGA_OFF = 2'h0,
		BCG_VGA_P2S = 2'h1,
		BCG_VGA_S2P = 2'h2,
		BCG_VGA_RSV = 2'h3
	} bcg_vga_type;
	typedef logic [3:0] bcg_nib_type;
endpackage

// *** core/bcg_gpio.sv ***
// Four general-purpose pins with set and clear nibbles
`timescale 1ns/1ns
`default_nettype none
`include "bcg_defines.svh"
module bcg_gpio (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	// Register write
	input  wire logic             wr_i,
	input  wire bcg_pkg::bcg_nib_type out_set_i,
	input  wire bcg_pkg::bcg_nib_type out_clr_i,
	input  wire bcg_pkg::bcg_nib_type oe_set_i,
	input  wire bcg_pkg::bcg_nib_type oe_clr_i,
	// Pin drive
	output logic [3:0]            out_o,
	output logic [3:0]            oe_o
);
	logic [3:0] out_ff;
	logic [3:0] oe_ff;
	logic [3:0] nxt_out;
	logic [3:0] nxt_oe;

	// Per-pin update, set beats clear, zero bits leave the pin alone
	for (genvar g = 0; g < 4; g++)
	begin : g_pin
		always_comb
		begin
			nxt_out[g] = out_ff[g];
			nxt_oe[g] = oe_ff[g];
			if (wr_i)
			begin
				nxt_out[g] = out_set_i[g] | (out_ff[g] & ~out_clr_i[g]);
				nxt_oe[g] = oe_set_i[g] | (oe_ff[g] & ~oe_clr_i[g]);
			end
		end
	end

	// State registers
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			out_ff <= `BCG_NIB_RST;
			oe_ff <= `BCG_NIB_RST;
		end
		else
		begin
			out_ff <= nxt_out;
			oe_ff <= nxt_oe;
		end
	end

	assign out_o = out_ff;
	assign oe_o = oe_ff;

	property p_gpio_keep;
		@(posedge clk_i) disable iff (!rstn_i)
		(wr_i && out_set_i == 4'h0 && out_clr_i == 4'h0) |=> $stable(out_o);
	endproperty
	a_gpio_keep: assert property (p_gpio_keep) else $error("gpio output moved on zero write");

	property p_gpio_set;
		@(posedge clk_i) disable iff (!rstn_i)
		(wr_i && oe_set_i != 4'h0) |=> ((oe_o & $past(oe_set_i)) == $past(oe_set_i));
	endproperty
	a_gpio_set: assert property (p_gpio_set) else $error("gpio enable set lost");
endmodule
`default_nettype wire

// *** core/bcg_vga.sv ***
// VGA window decode with direction and width selection
`timescale 1ns/1ns
`default_nettype none
`include "bcg_defines.svh"
module bcg_vga (
	// Clock and reset, checks only
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	// Mode
	input  wire bcg_pkg::bcg_vga_type mode_i,
	input  wire logic             dec16_i,
	// Access
	input  wire logic             vld_i,
	input  wire logic             io_i,
	input  wire logic             pri_i,
	input  wire logic [31:0]      addr_i,
	// Result
	output logic                  claim_o
);
	logic hit;
	logic dir_ok;

	// Window match, IO aliases above bit 9 unless wide decode
	always_comb
	begin
		hit = 1'b0;
		if (io_i)
		begin
			hit = (addr_i[9:0] >= 10'h3b0 && addr_i[9:0] <= 10'h3bb) ||
				(addr_i[9:0] >= 10'h3c0 && addr_i[9:0] <= 10'h3df);
			if (dec16_i)
				hit = hit && addr_i[15:10] == 6'h00;
		end
		else
			hit = addr_i[31:17] == 15'h0005;
		unique case (mode_i)
			bcg_pkg::BCG_VGA_P2S: dir_ok = pri_i;
			bcg_pkg::BCG_VGA_S2P: dir_ok = !pri_i;
			default: dir_ok = 1'b0;
		endcase
		claim_o = vld_i && hit && dir_ok;
	end

	property p_vga_off;
		@(posedge clk_i) disable iff (!rstn_i)
		(mode_i == bcg_pkg::BCG_VGA_OFF) |-> !claim_o;
	endproperty
	a_vga_off: assert property (p_vga_off) else $error("vga claimed while off");

	property p_vga_dir;
		@(posedge clk_i) disable iff (!rstn_i)
		claim_o |-> ((mode_i == bcg_pkg::BCG_VGA_P2S && pri_i) || (mode_i == bcg_pkg::BCG_VGA_S2P && !pri_i));
	endproperty
	a_vga_dir: assert property (p_vga_dir) else $error("vga claimed from wrong side");

	property p_vga_w16;
		@(posedge clk_i) disable iff (!rstn_i)
		(claim_o && io_i && dec16_i) |-> addr_i[15:10] == 6'h00;
	endproperty
	a_vga_w16: assert property (p_vga_w16) else $error("vga alias claimed in wide decode");

	c_vga_s2p: cover property (@(posedge clk_i) claim_o && !pri_i);
endmodule
`default_nettype wire

// *** dv/bcg_regs_tb.sv ***
// Self-checking testbench for the bridge control, GPIO and interrupt register block
`timescale 1ns/1ns
`default_nettype none
`include "bcg_defines.svh"
module bcg_regs_tb;
	logic        clk, rstn, we, re, rev, pcix, serr_n, vvld, vio, vpri, ma, ma_rd, tab_ok, serr_en, dexp;
	logic [8:0]  addr;
	logic [31:0] wdata, vaddr, rdata, ma_rdata;
	logic [3:0]  gin, gout, goe;
	logic [15:0] pri_len, sec_len;
	logic        fatal, nonfatal, serr_out_n, sec_rst_n, hot_rst, claim, ma_ones, ma_drop, ma_tab, irq;
	wire  [5:0]  ev = {fatal, nonfatal, ~serr_out_n, ma_ones, ma_drop, ma_tab};
	int          n_mismatch, n_compared;

	bcg_regs bcg_regs_inst (.CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we), .RE_I(re),
		.RDATA_O(rdata), .REVERSE_I(rev), .PCIX_MODE_I(pcix), .SERR_IN_N_I(serr_n), .ERR_FATAL_O(fatal),
		.ERR_NONFATAL_O(nonfatal), .SERR_OUT_N_O(serr_out_n), .SEC_RESET_N_O(sec_rst_n), .HOT_RESET_O(hot_rst),
		.VGA_VLD_I(vvld), .VGA_IO_I(vio), .VGA_PRI_I(vpri), .VGA_ADDR_I(vaddr), .VGA_CLAIM_O(claim),
		.MA_I(ma), .MA_RD_I(ma_rd), .TABORT_OK_I(tab_ok), .SERR_EN_I(serr_en), .MA_ONES_O(ma_ones),
		.MA_RDATA_O(ma_rdata), .MA_DROP_O(ma_drop), .MA_TABORT_O(ma_tab), .DISCARD_EXP_I(dexp),
		.PRI_DT_LEN_O(pri_len), .SEC_DT_LEN_O(sec_len), .GPIO_I(gin), .GPIO_O(gout), .GPIO_OE_O(goe), .IRQ_O(irq));

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Bit mask helper
	function automatic logic [31:0] fb(input int n);
		return 32'h1 << n;
	endfunction

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	// Register write, one cycle strobe
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
		#1;
	endtask

	// Register read, data checked in the following cycle
	task automatic rd(input logic [8:0] a, input logic [31:0] exp, input string m);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1;
		chk(rdata, exp, m);
	endtask

	// Collect event pulses over three cycles, each must last one cycle
	task automatic watch(input logic [5:0] exp, input string m);
		logic [5:0] seen;
		int         hits;
		seen = 6'h00;
		hits = 0;
		repeat (3)
		begin
			#1;
			seen = seen | ev;
			hits += $countones(ev);
			if (ma_ones === 1'b1)
				chk(ma_rdata, `BCG_MA_DATA, "abort read data");
			@(posedge clk);
		end
		chk(32'(seen), 32'(exp), m);
		chk(32'(hits), 32'($countones(exp)), m);
	endtask

	// Synchronous reset, held two cycles, forward mode
	task automatic do_reset;
		@(posedge clk);
		rstn <= 1'b0;
		rev <= 1'b0;
		pcix <= 1'b0;
		serr_n <= 1'b1;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
	endtask

	task automatic expire;
		@(posedge clk);
		dexp <= 1'b1;
		@(posedge clk);
		dexp <= 1'b0;
	endtask

	task automatic abort(input logic r, input logic t, input logic s);
		@(posedge clk);
		ma <= 1'b1;
		ma_rd <= r;
		tab_ok <= t;
		serr_en <= s;
		@(posedge clk);
		ma <= 1'b0;
	endtask

	task automatic t_reset;
		do_reset();
		rd(`BCG_OFS_CTL, 32'ha000_0000, "control reset");
		rd(`BCG_OFS_IST, 32'h0, "status reset");
		rd(`BCG_OFS_IMK, 32'h0, "mask reset");
		rd(9'h07c, 32'h0, "unmapped read");
		chk(sec_rst_n, 1'b1, "secondary reset idle");
		chk(pri_len, `BCG_DT_LONG, "primary length");
		chk(sec_len, `BCG_DT_LONG, "secondary length");
		$display("test reset done");
	endtask

	task automatic t_ctl;
		do_reset();
		wr(`BCG_OFS_CTL, 32'h0000_0fff);
		rd(`BCG_OFS_CTL, 32'ha000_0afc, "forward locked bits");
		chk(sec_rst_n, 1'b0, "secondary reset held");
		chk(hot_rst, 1'b0, "no hot reset forward");
		chk(sec_len, `BCG_DT_SHORT, "secondary short");
		@(posedge clk);
		rev <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(hot_rst, 1'b1, "hot reset reverse");
		chk(sec_rst_n, 1'b1, "bus reset off reverse");
		wr(`BCG_OFS_CTL, fb(8));
		rd(`BCG_OFS_CTL, 32'ha000_0304, "reverse locked bits");
		chk(hot_rst, 1'b0, "hot reset stops");
		chk(pri_len, `BCG_DT_SHORT, "primary short");
		$display("test control done");
	endtask

	task automatic t_vga;
		do_reset();
		for (int m = 0; m < 4; m++)
		begin
			wr(`BCG_OFS_CTL, 32'(m) << `BCG_B_VGA);
			for (int p = 0; p < 2; p++)
			begin
				for (int i = 0; i < 2; i++)
				begin
					@(posedge clk);
					vvld <= 1'b1;
					vio <= i[0];
					vpri <= p[0];
					vaddr <= i[0] ? 32'h0000_03c0 : 32'h000b_8000;
					#1;
					chk(claim, (m == 1 && p == 1) || (m == 2 && p == 0), "vga direction");
				end
			end
		end
		wr(`BCG_OFS_CTL, 32'h10);
		vaddr <= 32'h0000_43b0;
		#1;
		chk(claim, 1'b1, "ten bit decode");
		wr(`BCG_OFS_CTL, 32'h50);
		#1;
		chk(claim, 1'b0, "sixteen bit miss");
		vaddr <= 32'h0000_03b0;
		#1;
		chk(claim, 1'b1, "sixteen bit hit");
		vvld <= 1'b0;
		$display("test vga done");
	endtask

	task automatic t_serr;
		do_reset();
		wr(`BCG_OFS_CTL, fb(2));
		serr_n <= 1'b0;
		watch(6'b100000, "forwarded error");
		serr_n <= 1'b1;
		watch(6'b000000, "rising edge quiet");
		wr(`BCG_OFS_CTL, 32'h0);
		serr_n <= 1'b0;
		watch(6'b000000, "forwarding off");
		$display("test error forwarding done");
	endtask

	task automatic t_expiry;
		do_reset();
		wr(`BCG_OFS_CTL, fb(11));
		expire();
		watch(6'b010000, "expiry forward");
		rd(`BCG_OFS_CTL, 32'ha000_0000 | fb(11) | fb(10), "timeout flag set");
		wr(`BCG_OFS_CTL, fb(11) | fb(10));
		rd(`BCG_OFS_CTL, 32'ha000_0000 | fb(11), "timeout flag cleared");
		pcix <= 1'b1;
		expire();
		watch(6'b000000, "expiry in bus mode");
		rd(`BCG_OFS_CTL, 32'ha000_0000 | fb(11) | fb(10), "flag in bus mode");
		pcix <= 1'b0;
		rev <= 1'b1;
		expire();
		watch(6'b001000, "expiry reverse");
		wr(`BCG_OFS_CTL, fb(10));
		expire();
		watch(6'b000000, "expiry disabled");
		$display("test expiry done");
	endtask

	task automatic t_abort;
		do_reset();
		abort(1'b1, 1'b1, 1'b1);
		watch(6'b000100, "hidden read abort");
		abort(1'b0, 1'b1, 1'b1);
		watch(6'b000010, "hidden write abort");
		wr(`BCG_OFS_CTL, fb(7));
		abort(1'b1, 1'b1, 1'b1);
		watch(6'b000001, "target abort");
		abort(1'b0, 1'b0, 1'b1);
		watch(6'b001000, "abort error pin");
		abort(1'b0, 1'b0, 1'b0);
		watch(6'b000000, "abort unreported");
		$display("test master abort done");
	endtask

	task automatic t_gpio;
		do_reset();
		wr(`BCG_OFS_CTL, 32'h0305_0000);
		chk(gout, 4'h5, "value set");
		chk(goe, 4'h3, "enable set");
		gin <= 4'h6;
		rd(`BCG_OFS_CTL, 32'h6335_5000, "gpio readback");
		wr(`BCG_OFS_CTL, 32'h0010_1000);
		wr(`BCG_OFS_CTL, 32'h0);
		chk(gout, 4'h4, "value cleared");
		chk(goe, 4'h2, "enable cleared");
		wr(`BCG_OFS_CTL, 32'h0001_1000);
		chk(gout, 4'h5, "set beats clear");
		$display("test gpio done");
	endtask

	task automatic t_irq;
		do_reset();
		wr(`BCG_OFS_IMK, 32'h1);
		expire();
		#1;
		chk(irq, 1'b1, "interrupt raised");
		rd(`BCG_OFS_IST, 32'h1, "status bit");
		wr(`BCG_OFS_IMK, 32'h0);
		chk(irq, 1'b0, "interrupt masked");
		wr(`BCG_OFS_IMK, 32'h1);
		wr(`BCG_OFS_IST, 32'h7);
		chk(irq, 1'b0, "interrupt cleared");
		rd(`BCG_OFS_IST, 32'h0, "status cleared");
		$display("test interrupt done");
	endtask

	// Verdict and end of run
	task automatic report_and_stop;
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog, far beyond the some 170 cycles the tests need
	initial
	begin
		#200000;
		n_mismatch++;
		$display("FAIL at %0t: watchdog expired", $time);
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		{rstn, we, re, rev, pcix, vvld, vio, vpri, ma, ma_rd, tab_ok, serr_en, dexp} = '0;
		serr_n = 1'b1;
		addr = 9'h000;
		wdata = 32'h0;
		vaddr = 32'h0;
		gin = 4'ha;
		n_mismatch = 0;
		n_compared = 0;
		repeat (2) @(posedge clk);
		t_reset();
		t_ctl();
		t_vga();
		t_serr();
		t_expiry();
		t_abort();
		t_gpio();
		t_irq();
		report_and_stop();
	end
endmodule
`default_nettype wire
